// file: hw/pdm_consts.svh
// Constants of the port drive mode block: offsets, resets, fields
// Behaviour
// - Every port pin works as a digital input and output.
// - Each pin has four drive modes chosen by a two-bit code, upper bit from the high selector, lower from the low.
// - Pin n takes bit n of both selector registers as one grouped code.
// - Code 00 pulls high through a resistor and drives low strongly.
// - Code 01 drives high and low strongly.
// - Code 10 is high impedance both ways with the input buffer disabled; on the two serial programming pins it drives strongly instead.
// - Code 11 is high impedance high, input enabled, strong low (open drain).
// - In code 10 a read of the pin returns zero and the pin gives no useful interrupt; the two serial programming pins read and interrupt as in code 01.
// - Reset clears the low selector to 00 and sets the high selector to FFh, so every pin but the two serial programming pins starts analog.
// - The two serial programming pins do not come up high impedance after reset.
`ifndef PDM_CONSTS_SVH
`define PDM_CONSTS_SVH

`define PDM_OFS_DATA 12'h000
`define PDM_OFS_SEL_LO 12'h004
`define PDM_OFS_SEL_HI 12'h008
`define PDM_OFS_PIN_IN 12'h00C
`define PDM_RST_SEL_LO 8'h00
`define PDM_RST_SEL_HI 8'hFF
`define PDM_RST_DATA 8'h00
`define PDM_PROG_MASK 8'h03
`define PDM_PROG_CODE 2'h1

`endif

// file: hw/pdm_pkg.sv
// Types of the port drive mode block
package pdm_pkg;
    typedef enum logic [1:0] {
        PDM_RESISTIVE = 2'b00,
        PDM_STRONG = 2'b01,
        PDM_ANALOG = 2'b10,
        PDM_OPEN_DRAIN = 2'b11
    } pdm_code_t;
endpackage

// file: hw/pdm_port.sv
// Port drive mode logic with AHB-Lite register slave
`timescale 1ns/1ps
`include "pdm_consts.svh"
module pdm_port
    import pdm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [WIDTH-1:0] PIN_IN,
    output logic [WIDTH-1:0] PIN_OUT,
    output logic [WIDTH-1:0] PIN_OE_B,
    output logic [WIDTH-1:0] PIN_PULLUP,
    output logic [WIDTH-1:0] PIN_IBUF_EN,
    output logic [WIDTH-1:0] PIN_INT_VALID
);
    // ************************************
    // Bus slave
    // ************************************
    logic wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [WIDTH-1:0] data_r;
    logic [WIDTH-1:0] sel_lo_r;
    logic [WIDTH-1:0] sel_hi_r;
    logic [WIDTH-1:0] rd_pin_r;
    logic [31:0] hrdata_r;
    wire take = HSEL && HREADY && HTRANS[1];
    wire take_wr = take && HWRITE;
    wire take_rd = take && !HWRITE;
    wire [11:0] rd_addr = HADDR[11:0];
    wire [WIDTH-1:0] wdata = HWDATA[WIDTH-1:0];
    wire wr_data = wr_pend_r && (wr_addr_r == `PDM_OFS_DATA);
    wire wr_lo = wr_pend_r && (wr_addr_r == `PDM_OFS_SEL_LO);
    wire wr_hi = wr_pend_r && (wr_addr_r == `PDM_OFS_SEL_HI);
    wire [WIDTH-1:0] rd_sel =
        (rd_addr == `PDM_OFS_DATA) ? data_r :
        (rd_addr == `PDM_OFS_SEL_LO) ? sel_lo_r :
        (rd_addr == `PDM_OFS_SEL_HI) ? sel_hi_r :
        (rd_addr == `PDM_OFS_PIN_IN) ? rd_pin_r : '0;
    // Narrow data in the low bits, upper bits zero; unmapped reads zero
    wire [31:0] hrdata_nxt = take_rd ? {{(32-WIDTH){1'b0}}, rd_sel} : hrdata_r;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            hrdata_r <= 32'h00000000;
        end else begin
            wr_pend_r <= take_wr;
            wr_addr_r <= HADDR[11:0];
            hrdata_r <= hrdata_nxt;
        end
    end

    // ************************************
    // Selector and data registers
    // ************************************
    // reset to analog mode
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            sel_lo_r <= `PDM_RST_SEL_LO;
            sel_hi_r <= `PDM_RST_SEL_HI;
            data_r <= `PDM_RST_DATA;
        end else begin
            if (wr_lo) begin
                sel_lo_r <= wdata;
            end
            if (wr_hi) begin
                sel_hi_r <= wdata;
            end
            if (wr_data) begin
                data_r <= wdata;
            end
        end
    end

    // ************************************
    // Per pin drive decode
    // ************************************
    logic [WIDTH-1:0] out_nxt;
    logic [WIDTH-1:0] oe_b_nxt;
    logic [WIDTH-1:0] pu_nxt;
    logic [WIDTH-1:0] ibuf_nxt;
    logic [WIDTH-1:0] rd_pin_nxt;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] oe_b_r;
    logic [WIDTH-1:0] pu_r;
    logic [WIDTH-1:0] ibuf_r;

    // Mask held as a sized constant so single bits can be picked per pin
    localparam logic [7:0] PROG_MASK = `PDM_PROG_MASK;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_pin
            // group bit n of both selectors
            wire [1:0] raw_code = {sel_hi_r[gi], sel_lo_r[gi]};
            wire prog_pin = (gi < 8) && PROG_MASK[gi % 8];
            wire [1:0] code = (prog_pin && raw_code == PDM_ANALOG) ? `PDM_PROG_CODE : raw_code;
            assign out_nxt[gi] = data_r[gi];
            assign oe_b_nxt[gi] = (code == PDM_STRONG) ? 1'b0 :
                                  (code == PDM_RESISTIVE || code == PDM_OPEN_DRAIN) ? data_r[gi] : 1'b1;
            assign pu_nxt[gi] = (code == PDM_RESISTIVE);
            assign ibuf_nxt[gi] = (code != PDM_ANALOG);
            assign rd_pin_nxt[gi] = ibuf_nxt[gi] & PIN_IN[gi];
        end
    endgenerate

    // Registered so that every pin output leaves a flip-flop
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            out_r <= '0;
            oe_b_r <= '1;
            pu_r <= '0;
            ibuf_r <= '0;
            rd_pin_r <= '0;
        end else begin
            out_r <= out_nxt;
            oe_b_r <= oe_b_nxt;
            pu_r <= pu_nxt;
            ibuf_r <= ibuf_nxt;
            rd_pin_r <= rd_pin_nxt;
        end
    end

    assign PIN_OUT = out_r;
    assign PIN_OE_B = oe_b_r;
    assign PIN_PULLUP = pu_r;
    assign PIN_IBUF_EN = ibuf_r;
    assign PIN_INT_VALID = ibuf_r;
    assign HRDATA = hrdata_r;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
endmodule

// file: sim/pdm_pads.sv
// Board model: pin level from drive, pull-up and float
`timescale 1ns/1ps
module pdm_pads(
    input wire logic [7:0] drv,
    input wire logic [7:0] oe_b,
    input wire logic [7:0] pull,
    input wire logic [7:0] flt,
    output logic [7:0] pin
);
    assign pin = (~oe_b & drv) | (oe_b & (pull | flt));
endmodule

// file: sim/pdm_port_props.sv
// Port checker for pdm_port
`timescale 1ns/1ps
module pdm_port_props(
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic HSEL,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [31:0] HADDR,
    input wire logic [31:0] HWDATA,
    input wire logic [31:0] HRDATA,
    input wire logic [1:0] HTRANS,
    input wire logic [7:0] PIN_OUT,
    input wire logic [7:0] PIN_OE_B,
    input wire logic [7:0] PIN_PULLUP,
    input wire logic [7:0] PIN_IBUF_EN,
    input wire logic [7:0] PIN_INT_VALID
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    sequence wr_data;
        HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[11:0] == 12'h000 ##1 1'b1;
    endsequence
    a_bus_okay: assert property (HREADYOUT && !HRESP) else $error("bus resp");
    a_rd_upper: assert property (HRDATA[31:8] == 24'h000000) else $error("rd upper");
    a_analog_off: assert property ((~PIN_IBUF_EN & ~PIN_OE_B) == 8'h00) else $error("analog driven");
    a_int_valid: assert property (PIN_INT_VALID == PIN_IBUF_EN) else $error("int valid");
    a_pull_low: assert property ((PIN_PULLUP & ~PIN_OE_B & PIN_OUT) == 8'h00) else $error("pull high");
    a_prog_pins: assert property ($past(RST_B) |-> PIN_IBUF_EN[1:0] == 2'h3) else $error("prog pins");
    a_reset_analog: assert property ($rose(RST_B) |=> PIN_OE_B[7:2] == 6'h3F) else $error("reset mode");
    a_data_pin: assert property (wr_data |=> ##1 PIN_OUT == $past(HWDATA[7:0], 2)) else $error("out");
endmodule
bind pdm_port pdm_port_props chk (.*);

// file: sim/pdm_port_tb.sv
// Self-checking bench for pdm_port
`timescale 1ns/1ps
`include "pdm_consts.svh"
module pdm_port_tb;
    logic MCLK = 0, RST_B = 0, HWRITE = 0, HREADYOUT, HRESP, chk = 0;
    logic [1:0] HTRANS = 2'h0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
    logic [31:0] q[$];
    logic [7:0] PIN_IN, PIN_OUT, PIN_OE_B, PIN_PULLUP, flt = 8'h00, d, l, h;
    int n_fail = 0, compares = 0, cyc = 0, seed = 32'h184f7efa;
    always #20 MCLK = ~MCLK;
    pdm_port uut (.*, .HSEL(1'b1), .HSIZE(3'h2), .HREADY(HREADYOUT), .PIN_IBUF_EN(), .PIN_INT_VALID());
    pdm_pads pads (.drv(PIN_OUT), .oe_b(PIN_OE_B), .pull(PIN_PULLUP), .flt(flt), .pin(PIN_IN));
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] v);
        @(posedge MCLK);
        HADDR <= {20'h0, a};
        HWRITE <= w;
        HTRANS <= 2'h2;
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= v;
        chk <= !w;
        if (!w) q.push_back(v);
        do @(posedge MCLK); while (HREADYOUT !== 1'b1);
        chk <= 0;
    endtask
    task final_report;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Read results checked oldest first
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (chk === 1'b1) begin
            compares++;
            if (HRDATA !== q[0]) begin
                n_fail++;
                $display("BAD hrdata exp %h got %h", q[0], HRDATA);
            end
            void'(q.pop_front());
        end
        if (cyc == 3000) begin
            n_fail++;
            final_report;
        end
    end
    initial begin
        repeat (12) @(posedge MCLK);
        RST_B <= 1;
        xfer(`PDM_OFS_SEL_LO, 0, 32'h0);
        xfer(`PDM_OFS_SEL_HI, 0, 32'hFF);
        xfer(12'h010, 0, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            l = $random(seed);
            h = $random(seed);
            flt <= $random(seed);
            if (i == 0) begin
                {d, l, h} = 24'hFFFFFF;
            end
            xfer(`PDM_OFS_DATA, 1, {24'h0, d});
            xfer(`PDM_OFS_SEL_LO, 1, {24'h0, l});
            xfer(`PDM_OFS_SEL_HI, 1, {24'h0, h});
            xfer(`PDM_OFS_SEL_LO, 0, {24'h0, l});
            xfer(`PDM_OFS_SEL_HI, 0, {24'h0, h});
            xfer(`PDM_OFS_PIN_IN, 0, {24'h0, d & (~(h & l) | flt) & ~(h & ~l & ~`PDM_PROG_MASK)});
        end
        $display("test modes done");
        final_report;
    end
endmodule
